// ### rtl/crr_pkg.sv
// Package for the return, reset and rotate execution block
package crr_pkg;
    localparam int CRR_DATA_W = 8;
    localparam int CRR_PC_W = 15;
    localparam int CRR_FADDR_W = 7;
    localparam int CRR_STACK_DEPTH = 16;
    localparam int CRR_SP_W = 4;
    localparam int CRR_OP_W = 3;

    // Operation codes handed over by the decode path
    localparam logic [2:0] CRR_OP_NOP = 3'h0;
    localparam logic [2:0] CRR_OP_OPTION = 3'h1;
    localparam logic [2:0] CRR_OP_RESET = 3'h2;
    localparam logic [2:0] CRR_OP_RET_IRQ = 3'h3;
    localparam logic [2:0] CRR_OP_RETURN = 3'h4;
    localparam logic [2:0] CRR_OP_RET_LIT = 3'h5;
    localparam logic [2:0] CRR_OP_ROT_LEFT = 3'h6;
    localparam logic [2:0] CRR_OP_CALL = 3'h7;

    localparam int CRR_IRQ_EN_BIT = 7;
    localparam int CRR_CYC_RET = 2;
    localparam int CRR_CYC_SINGLE = 1;

    // AXI4-Lite register byte addresses
    localparam logic [7:0] CRR_A_ACC = 8'h00;
    localparam logic [7:0] CRR_A_PC = 8'h04;
    localparam logic [7:0] CRR_A_OPTION = 8'h08;
    localparam logic [7:0] CRR_A_IRQCTL = 8'h0C;
    localparam logic [7:0] CRR_A_PWRCTL = 8'h10;
    localparam logic [7:0] CRR_A_STATUS = 8'h14;
    localparam logic [7:0] CRR_A_SP = 8'h18;
    localparam logic [7:0] CRR_A_FILE = 8'h1C;

    localparam logic [7:0] CRR_ACC_RST = 8'h00;
    localparam logic [7:0] CRR_OPTION_RST = 8'hFF;
    localparam logic [7:0] CRR_IRQCTL_RST = 8'h00;
    localparam logic [7:0] CRR_PWRCTL_RST = 8'h01;
    localparam int CRR_RI_BIT = 0;
    localparam int CRR_STAT_C_BIT = 0;
    localparam int CRR_STAT_BUSY_BIT = 1;
    localparam logic [1:0] CRR_RESP_OKAY = 2'h0;
    localparam logic [1:0] CRR_RESP_SLVERR = 2'h2;
endpackage

// ### rtl/crr_core.sv
// Execution unit for no-op, option load, soft reset, returns and rotate-left
module crr_core
    import crr_pkg::*;
#(
    parameter int STACK_DEPTH = CRR_STACK_DEPTH,
    parameter int FILE_DEPTH = 128
) (
    input wire logic aclk,
    input wire logic aresetn,
    // Decoded instruction
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [2:0] instr_op,
    input wire logic [7:0] instr_lit,
    input wire logic [6:0] instr_faddr,
    input wire logic instr_dest,
    input wire logic [14:0] instr_target,
    output logic instr_done,
    output logic soft_reset_pulse,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [1:0] {
        CRR_ST_IDLE = 2'b01,
        CRR_ST_SECOND = 2'b10
    } crr_state_e;

    typedef struct packed {
        crr_state_e st;
        logic [7:0] acc;
        logic [14:0] pc;
        logic [7:0] option_reg;
        logic [7:0] irq_control_register;
        logic [7:0] power_control_register;
        logic carry;
        logic [3:0] sp;
        logic [STACK_DEPTH-1:0][14:0] stack;
        logic [FILE_DEPTH-1:0][7:0] file;
        logic [6:0] file_sel;
        logic done;
        logic rst_pulse;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } crr_s;

    crr_s q;
    crr_s next_q;
    logic [7:0] rot_src;
    logic [14:0] top_of_return_stack;
    logic [3:0] pop_sp;

    assign pop_sp = q.sp - 4'h1;
    assign top_of_return_stack = q.stack[pop_sp];
    assign rot_src = q.file[instr_faddr];
    assign instr_ready = (q.st == CRR_ST_IDLE) && !q.rst_pulse;
    assign instr_done = q.done;
    assign soft_reset_pulse = q.rst_pulse;
    assign s_axi_awready = !q.aw_held && !q.bvalid;
    assign s_axi_wready = !q.w_held && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    always_comb begin
        logic accept;
        accept = instr_valid && instr_ready;
        next_q = q;
        next_q.done = 1'b0;
        next_q.rst_pulse = 1'b0;
        // Register bus: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_q.aw_held = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_q.w_held = 1'b1;
            next_q.w_data = s_axi_wdata;
            next_q.w_strb = s_axi_wstrb;
        end
        if (q.aw_held && q.w_held) begin
            next_q.aw_held = 1'b0;
            next_q.w_held = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = CRR_RESP_OKAY;
            // Low lane only; the instruction below overrides a colliding bus write
            if (q.w_strb[0]) begin
                unique case (q.aw_addr)
                    CRR_A_ACC: next_q.acc = q.w_data[7:0];
                    CRR_A_OPTION: next_q.option_reg = q.w_data[7:0];
                    CRR_A_IRQCTL: next_q.irq_control_register = q.w_data[7:0];
                    CRR_A_PWRCTL: next_q.power_control_register = q.w_data[7:0];
                    CRR_A_SP: next_q.file_sel = q.w_data[6:0];
                    CRR_A_FILE: next_q.file[q.file_sel] = q.w_data[7:0];
                    CRR_A_PC, CRR_A_STATUS: next_q.bresp = CRR_RESP_OKAY;
                    default: next_q.bresp = CRR_RESP_SLVERR;
                endcase
            end
        end
        if (q.st == CRR_ST_SECOND) begin
            // Second cycle of a return; the PC was already loaded
            next_q.st = CRR_ST_IDLE;
            next_q.done = 1'b1;
        end else if (accept) begin
            unique case (instr_op)
                CRR_OP_NOP: begin
                    next_q.pc = q.pc + 15'h1;
                    next_q.done = 1'b1;
                end
                CRR_OP_OPTION: begin
                    next_q.option_reg = q.acc;
                    next_q.pc = q.pc + 15'h1;
                    next_q.done = 1'b1;
                end
                CRR_OP_RESET: begin
                    // Only the pulse is raised here; the core reset below clears the flag a cycle later
                    next_q.rst_pulse = 1'b1;
                end
                CRR_OP_RET_IRQ: begin
                    next_q.pc = top_of_return_stack;
                    next_q.sp = pop_sp;
                    next_q.irq_control_register[CRR_IRQ_EN_BIT] = 1'b1;
                    next_q.st = CRR_ST_SECOND;
                end
                CRR_OP_RETURN: begin
                    next_q.pc = top_of_return_stack;
                    next_q.sp = pop_sp;
                    next_q.st = CRR_ST_SECOND;
                end
                CRR_OP_RET_LIT: begin
                    next_q.acc = instr_lit;
                    next_q.pc = top_of_return_stack;
                    next_q.sp = pop_sp;
                    next_q.st = CRR_ST_SECOND;
                end
                CRR_OP_ROT_LEFT: begin
                    next_q.carry = rot_src[CRR_DATA_W-1];
                    if (instr_dest) begin
                        next_q.file[instr_faddr] = {rot_src[6:0], q.carry};
                    end else begin
                        next_q.acc = {rot_src[6:0], q.carry};
                    end
                    next_q.pc = q.pc + 15'h1;
                    next_q.done = 1'b1;
                end
                CRR_OP_CALL: begin
                    // Push support so returns have something to pop
                    next_q.stack[q.sp] = q.pc + 15'h1;
                    next_q.sp = q.sp + 4'h1;
                    next_q.pc = instr_target;
                    next_q.done = 1'b1;
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = CRR_RESP_OKAY;
            next_q.rdata = 32'h0;
            unique case (s_axi_araddr)
                CRR_A_ACC: next_q.rdata[7:0] = q.acc;
                CRR_A_PC: next_q.rdata[14:0] = q.pc;
                CRR_A_OPTION: next_q.rdata[7:0] = q.option_reg;
                CRR_A_IRQCTL: next_q.rdata[7:0] = q.irq_control_register;
                CRR_A_PWRCTL: next_q.rdata[7:0] = q.power_control_register;
                CRR_A_STATUS: begin
                    next_q.rdata[CRR_STAT_C_BIT] = q.carry;
                    next_q.rdata[CRR_STAT_BUSY_BIT] = (q.st == CRR_ST_SECOND);
                end
                CRR_A_SP: next_q.rdata[3:0] = q.sp;
                CRR_A_FILE: next_q.rdata[7:0] = q.file[q.file_sel];
                default: next_q.rresp = CRR_RESP_SLVERR;
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        if (q.rst_pulse) begin
            // Core state returns to reset values, save that power control only has its RI bit cleared; the bus side keeps running so
            // that a transfer in flight is still answered
            next_q.st = CRR_ST_IDLE;
            next_q.acc = CRR_ACC_RST;
            next_q.pc = '0;
            next_q.option_reg = CRR_OPTION_RST;
            next_q.irq_control_register = CRR_IRQCTL_RST;
            next_q.power_control_register[CRR_RI_BIT] = 1'b0;
            next_q.carry = 1'b0;
            next_q.sp = '0;
            next_q.stack = '0;
            next_q.file = '0;
            next_q.file_sel = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q.st <= CRR_ST_IDLE;
            q.acc <= CRR_ACC_RST;
            q.pc <= '0;
            q.option_reg <= CRR_OPTION_RST;
            q.irq_control_register <= CRR_IRQCTL_RST;
            q.power_control_register <= CRR_PWRCTL_RST;
            q.carry <= 1'b0;
            q.sp <= '0;
            q.stack <= '0;
            q.file <= '0;
            q.file_sel <= '0;
            q.done <= 1'b0;
            q.rst_pulse <= 1'b0;
            q.aw_held <= 1'b0;
            q.aw_addr <= '0;
            q.w_held <= 1'b0;
            q.w_data <= '0;
            q.w_strb <= '0;
            q.bvalid <= 1'b0;
            q.bresp <= '0;
            q.rvalid <= 1'b0;
            q.rdata <= '0;
            q.rresp <= '0;
        end else begin
            q <= next_q;
        end
    end

    sequence s_ret_take;
        instr_valid && instr_ready && (instr_op == CRR_OP_RET_IRQ);
    endsequence

    property p_ret_irq_pc;
        @(posedge aclk) disable iff (!aresetn)
        s_ret_take |=> (q.pc == $past(top_of_return_stack)) && (q.sp == $past(pop_sp));
    endproperty
    a_ret_irq_pc: assert property (p_ret_irq_pc) else $error("irq return pc wrong");

    property p_ret_irq_en;
        @(posedge aclk) disable iff (!aresetn)
        s_ret_take |=> q.irq_control_register[CRR_IRQ_EN_BIT];
    endproperty
    a_ret_irq_en: assert property (p_ret_irq_en) else $error("enable not set");

    property p_ret_irq_two;
        @(posedge aclk) disable iff (!aresetn)
        s_ret_take |=> !instr_ready ##1 (instr_done && $stable(q.carry));
    endproperty
    a_ret_irq_two: assert property (p_ret_irq_two) else $error("irq return timing");

    property p_return;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_RETURN)
            |=> q.pc == $past(top_of_return_stack) ##1 instr_done;
    endproperty
    a_return: assert property (p_return) else $error("return wrong");

    property p_retlit;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_RET_LIT)
            |=> (q.acc == $past(instr_lit)) && (q.carry == $past(q.carry));
    endproperty
    a_retlit: assert property (p_retlit) else $error("literal return wrong");

    property p_rot;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_ROT_LEFT && !instr_dest)
            |=> (q.acc == {$past(rot_src[6:0]), $past(q.carry)}) && (q.carry == $past(rot_src[7]));
    endproperty
    a_rot: assert property (p_rot) else $error("rotate wrong");

    property p_option;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_OPTION)
            |=> (q.option_reg == $past(q.acc)) && instr_done;
    endproperty
    a_option: assert property (p_option) else $error("option load wrong");

    property p_nop;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_NOP)
            |=> (q.pc == $past(q.pc) + 15'h1) && $stable(q.acc) && instr_done;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

    property p_reset;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_RESET)
            |=> ##1 (q.pc == 15'h0) && !q.power_control_register[CRR_RI_BIT];
    endproperty
    a_reset: assert property (p_reset) else $error("soft reset wrong");

    property p_soft_pulse;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_RESET)
            |=> soft_reset_pulse && !instr_ready && !instr_done;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse missing");

    property p_rot_file;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_ROT_LEFT && instr_dest)
            |=> (q.file[$past(instr_faddr)] == {$past(rot_src[6:0]), $past(q.carry)})
            && (q.carry == $past(rot_src[CRR_DATA_W-1])) && (q.acc == $past(q.acc));
    endproperty
    a_rot_file: assert property (p_rot_file) else $error("rotate to file wrong");

    property p_retlit_pc;
        @(posedge aclk) disable iff (!aresetn)
        (instr_valid && instr_ready && instr_op == CRR_OP_RET_LIT)
            |=> q.pc == $past(top_of_return_stack) ##1 instr_done;
    endproperty
    a_retlit_pc: assert property (p_retlit_pc) else $error("literal return pc wrong");
endmodule

// ### dv/tb_cpu_return_reset_rotate_ops.sv
// Self-checking bench for the return, reset and rotate execution unit
module tb_cpu_return_reset_rotate_ops import crr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0] op;
        logic [7:0] acc;
        logic [7:0] lit;
        logic [7:0] ra;
        logic [31:0] exp;
        int cyc;
    } crr_row_s;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic instr_valid = 1'h0;
    logic instr_dest = 1'h0;
    logic [2:0] instr_op = 3'h0;
    logic [7:0] instr_lit = 8'h00;
    logic [6:0] instr_faddr = 7'h00;
    logic [14:0] instr_target = 15'h0000;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic instr_ready, instr_done, soft_reset_pulse, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int failures = 0;
    int num_checks = 0;
    // Carry is 1 before every row, so a flag disturbed by these ops shows up
    crr_row_s rows [5] = '{
        '{CRR_OP_OPTION, 8'h4F, 8'h00, CRR_A_OPTION, 32'h4F, 1},
        '{CRR_OP_NOP, 8'h33, 8'h00, CRR_A_ACC, 32'h33, 1},
        '{CRR_OP_RET_LIT, 8'h11, 8'hFF, CRR_A_ACC, 32'hFF, 2},
        '{CRR_OP_RET_LIT, 8'h11, 8'h00, CRR_A_ACC, 32'h00, 2},
        '{CRR_OP_RETURN, 8'h5A, 8'h00, CRR_A_ACC, 32'h5A, 2}};

    crr_core #(.STACK_DEPTH(CRR_STACK_DEPTH), .FILE_DEPTH(128)) dut (
        .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr_op(instr_op), .instr_lit(instr_lit),
        .instr_faddr(instr_faddr), .instr_dest(instr_dest), .instr_target(instr_target),
        .instr_done(instr_done), .soft_reset_pulse(soft_reset_pulse),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    always #12.5 aclk = ~aclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d, exp);
    endtask

    // Cycles are counted from the taking edge to the done or reset pulse
    task automatic ex(input logic [2:0] op, input logic [7:0] lit, input logic [6:0] fa,
        input logic d, input logic [14:0] tgt, output int n, output logic p);
        @(posedge aclk);
        instr_op <= op;
        instr_lit <= lit;
        instr_faddr <= fa;
        instr_dest <= d;
        instr_target <= tgt;
        instr_valid <= 1'h1;
        do @(posedge aclk); while (instr_ready !== 1'h1);
        instr_valid <= 1'h0;
        for (n = 1; n < 40; n++) begin
            @(negedge aclk);
            if (instr_done === 1'h1 || soft_reset_pulse === 1'h1) break;
        end
        p = soft_reset_pulse;
    endtask

    initial begin
        #(25 * 20000);
        failures++;
        wrap_up();
    end

    initial begin
        int n;
        logic p;
        logic [31:0] d, pc0;
        logic [1:0] r;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rdc(CRR_A_OPTION, 32'hFF);
        rdc(CRR_A_PWRCTL, 32'h01);
        rdc(CRR_A_ACC, 32'h00);
        rdc(CRR_A_IRQCTL, 32'h00);
        wr(CRR_A_SP, 32'h05, r);
        wr(CRR_A_FILE, 32'hE6, r);
        ex(CRR_OP_ROT_LEFT, 8'h00, 7'h05, 1'h0, 15'h0, n, p);
        check(32'(n), 32'h1);
        rdc(CRR_A_ACC, 32'hCC);
        rdc(CRR_A_FILE, 32'hE6);
        rdc(CRR_A_STATUS, 32'h1);
        ex(CRR_OP_ROT_LEFT, 8'h00, 7'h05, 1'h1, 15'h0, n, p);
        rdc(CRR_A_FILE, 32'hCD);
        rdc(CRR_A_ACC, 32'hCC);
        wr(CRR_A_SP, 32'h7F, r);
        wr(CRR_A_FILE, 32'h80, r);
        ex(CRR_OP_ROT_LEFT, 8'h00, 7'h7F, 1'h1, 15'h0, n, p);
        rdc(CRR_A_FILE, 32'h01);
        rdc(CRR_A_STATUS, 32'h1);
        foreach (rows[i]) begin
            wr(CRR_A_ACC, 32'(rows[i].acc), r);
            rd(CRR_A_PC, pc0, r);
            ex(CRR_OP_CALL, 8'h00, 7'h00, 1'h0, 15'(16'h1230 + i), n, p);
            ex(rows[i].op, rows[i].lit, 7'h00, 1'h0, 15'h0, n, p);
            check(32'(n), 32'(rows[i].cyc));
            rdc(rows[i].ra, rows[i].exp);
            rdc(CRR_A_STATUS, 32'h1);
            rdc(CRR_A_PC, (rows[i].cyc == 2) ? pc0 + 1 : 32'h1231 + i);
        end
        wr(CRR_A_IRQCTL, 32'h05, r);
        rd(CRR_A_PC, pc0, r);
        ex(CRR_OP_CALL, 8'h00, 7'h00, 1'h0, 15'h0100, n, p);
        ex(CRR_OP_RET_IRQ, 8'h00, 7'h00, 1'h0, 15'h0, n, p);
        check(32'(n), 32'h2);
        rdc(CRR_A_IRQCTL, 32'h85);
        rdc(CRR_A_PC, pc0 + 1);
        rdc(CRR_A_STATUS, 32'h1);
        // Top bit clear: carry must drop to zero
        ex(CRR_OP_ROT_LEFT, 8'h00, 7'h7F, 1'h1, 15'h0, n, p);
        rdc(CRR_A_FILE, 32'h03);
        rdc(CRR_A_STATUS, 32'h0);
        rdc(CRR_A_SP, 32'h2);
        // Unmapped place on both channels
        wr(8'h20, 32'h5A, r);
        check(32'(r), 32'(CRR_RESP_SLVERR));
        rd(8'h20, d, r);
        check(32'(r), 32'(CRR_RESP_SLVERR));
        check(d, 32'h0);
        wr(CRR_A_OPTION, 32'h12, r);
        wr(CRR_A_ACC, 32'h77, r);
        ex(CRR_OP_RESET, 8'h00, 7'h00, 1'h0, 15'h0, n, p);
        check(32'(p), 32'h1);
        check(32'(n), 32'h1);
        repeat (2) @(posedge aclk);
        rdc(CRR_A_OPTION, 32'hFF);
        rdc(CRR_A_ACC, 32'h00);
        rdc(CRR_A_IRQCTL, 32'h00);
        rdc(CRR_A_PC, 32'h0);
        rdc(CRR_A_PWRCTL, 32'h00);
        rdc(CRR_A_SP, 32'h0);
        // Pin reset in mid-run brings the flag back, unlike the soft reset
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rdc(CRR_A_PWRCTL, 32'h01);
        wrap_up();
    end
endmodule
